/* File: src/psram_slave_pkg.sv */
/*
 * Shared constants for the pseudo-static DRAM slave port: the
 * command-address layout, wrap encodings, timing figures and the
 * transfer states.
 * Assumes a 10 MHz system clock that oversamples the bus pins.
 */
`default_nettype none

package psram_slave_pkg;

    // ****************************************************************
    // bus widths and command-address layout
    // ****************************************************************
    localparam int BYTE_W        = 8;
    localparam int WORD_W        = 16;
    localparam int CA_BYTES      = 6;
    localparam int CA_W          = CA_BYTES * BYTE_W;
    localparam int CA_RW_BIT     = 47;
    localparam int CA_LINEAR_BIT = 45;
    localparam int EDGES_PER_CLK = 2;
    localparam int LAT_MULT_EXT  = 2;
    localparam int CNT_W         = 8;

    // ****************************************************************
    // pin synchroniser layout: {reset, mask, select, clock, data}
    // ****************************************************************
    localparam int              SYNC_W   = 12;
    localparam logic [SYNC_W-1:0] SYNC_RST = 12'ha00;

    // ****************************************************************
    // wrapped burst lengths
    // ****************************************************************
    localparam logic [1:0] WRAP_SEL_16B  = 2'h0;
    localparam logic [1:0] WRAP_SEL_32B  = 2'h1;
    localparam logic [1:0] WRAP_SEL_64B  = 2'h2;
    localparam logic [1:0] WRAP_SEL_128B = 2'h3;
    localparam int WRAP_WORDS_16B  = 8;
    localparam int WRAP_WORDS_32B  = 16;
    localparam int WRAP_WORDS_64B  = 32;
    localparam int WRAP_WORDS_128B = 64;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int SYS_CLK_PERIOD_NS   = 100;
    localparam int BUS_CLK_MAX_MHZ     = 200;
    localparam int INIT_ACCESS_TIME_NS = 35;
    localparam int ACC_CYC = (INIT_ACCESS_TIME_NS / SYS_CLK_PERIOD_NS < 1) ? 1 :
                             INIT_ACCESS_TIME_NS / SYS_CLK_PERIOD_NS;

    // ****************************************************************
    // transfer states
    // ****************************************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CA   = 2'b01,
        ST_LAT  = 2'b10,
        ST_DATA = 2'b11
    } xfer_state_e;

endpackage

`default_nettype wire

/* File: src/psram_word_array.sv */
/*
 * Word storage of the pseudo-static DRAM: flip-flops addressed by
 * word index, with a byte-enabled write and a registered read.
 * Assumes one address shared by read and write.
 */
`timescale 1ns/10ps
`default_nettype none

module psram_word_array
    import psram_slave_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock
    input  wire logic              i_clk_sys,
    // write side
    input  wire logic              i_wr_en,
    input  wire logic [1:0]        i_wr_be,
    input  wire logic [WORD_W-1:0] i_wr_data,
    // shared address and read data
    input  wire logic [ADDR_W-1:0] i_addr,
    output logic      [WORD_W-1:0] o_rd_data
);

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [WORD_W-1:0] mem_ff [2**ADDR_W];

    always_ff @(posedge i_clk_sys) begin
        if (i_wr_en && i_wr_be[1]) begin
            mem_ff[i_addr][WORD_W-1:BYTE_W] <= i_wr_data[WORD_W-1:BYTE_W];
        end
        if (i_wr_en && i_wr_be[0]) begin
            mem_ff[i_addr][BYTE_W-1:0] <= i_wr_data[BYTE_W-1:0];
        end
    end

    // read word lands one cycle after the address settles
    always_ff @(posedge i_clk_sys) begin
        o_rd_data <= mem_ff[i_addr];
    end

endmodule

`default_nettype wire

/* File: src/ddr_psram_slave_port.sv */
/*
 * Device-side transaction logic of a self-refreshing pseudo-static
 * DRAM on an eight-bit double-data-rate bus.
 * Assumes the host clock is far slower than i_clk_sys (at least four
 * system cycles per half period) so every bus edge is seen.
 */
// Summary of operation
// - select, six cmd bytes, latency, data
// - one word per clock, two bytes
// - capture inputs on bus clock edges
// - drive strobe line at transaction start
// - strobe high in cmd phase if refresh
// - strobe toggles with each read byte
// - read data edge-aligned with strobe
// - host drives write mask on strobe
// - masked byte unchanged, unmasked byte written
// - linear and 16-128 byte wrapped bursts
// - hybrid: one wrap then linear
// - linear burst never crosses die boundary
// - die end wraps to die start
// - refresh runs itself only when idle
// - latency always the extended setting
// - bus clock at most 200 MHz; oversampled at 10 MHz here, so at most 1.25 MHz
// - first read word within access time
`timescale 1ns/10ps
`default_nettype none

module ddr_psram_slave_port
    import psram_slave_pkg::*;
#(
    parameter int ADDR_W               = 8,
    parameter int LAT_CLKS             = 6,
    parameter int REFRESH_INTERVAL_CYC = 2000,
    parameter int REFRESH_PENALTY_CYC  = 8
) (
    // system
    input  wire logic              i_clk_sys,
    input  wire logic              i_resetn,
    // bus pins
    input  wire logic              i_cs_n,
    input  wire logic              i_bus_clk_true,
    input  wire logic              i_hw_reset_n,
    input  wire logic [BYTE_W-1:0] i_dq,
    output logic      [BYTE_W-1:0] o_dq,
    output logic                   o_dq_oe,
    input  wire logic              i_strobe_mask_line,
    output logic                   o_strobe_mask_line,
    output logic                   o_strobe_mask_oe,
    // burst setup
    input  wire logic [1:0]        i_wrap_len_sel,
    input  wire logic              i_hybrid_en,
    // status
    output logic                   o_refresh_pending
);

    localparam logic [CNT_W-1:0] CA_LAST  = CNT_W'(CA_BYTES - 1);
    localparam logic [CNT_W-1:0] LAT_LAST =
        CNT_W'(LAT_MULT_EXT * EDGES_PER_CLK * LAT_CLKS - 1);
    localparam int INTV_W = $clog2(REFRESH_INTERVAL_CYC);
    localparam int PEN_W  = $clog2(REFRESH_PENALTY_CYC + 1);
    localparam logic [INTV_W-1:0] INTV_LAST = INTV_W'(REFRESH_INTERVAL_CYC - 1);
    localparam logic [PEN_W-1:0]  PEN_LAST  = PEN_W'(REFRESH_PENALTY_CYC - 1);

    // ****************************************************************
    // address arithmetic
    // ****************************************************************
    function automatic logic [ADDR_W-1:0] wrap_mask(input logic [1:0] sel);
        case (sel)
            WRAP_SEL_16B:  wrap_mask = ADDR_W'(WRAP_WORDS_16B - 1);
            WRAP_SEL_32B:  wrap_mask = ADDR_W'(WRAP_WORDS_32B - 1);
            WRAP_SEL_64B:  wrap_mask = ADDR_W'(WRAP_WORDS_64B - 1);
            WRAP_SEL_128B: wrap_mask = ADDR_W'(WRAP_WORDS_128B - 1);
            default:       wrap_mask = ADDR_W'(WRAP_WORDS_16B - 1);
        endcase
    endfunction

    // die end wraps to start
    // die bit held, so the count rolls over inside the die
    function automatic logic [ADDR_W-1:0] lin_inc(input logic [ADDR_W-1:0] a);
        lin_inc = {a[ADDR_W-1], a[ADDR_W-2:0] + 1'b1};
    endfunction

    function automatic logic [ADDR_W-1:0] wrap_inc(input logic [ADDR_W-1:0] a,
                                                   input logic [ADDR_W-1:0] m);
        wrap_inc = (a & ~m) | ((a + 1'b1) & m);
    endfunction

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // slow host clock oversampled
    logic [SYNC_W-1:0] sync1_ff;
    logic [SYNC_W-1:0] sync2_ff;
    logic              bclk_prev_ff;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            sync1_ff     <= SYNC_RST;
            sync2_ff     <= SYNC_RST;
            bclk_prev_ff <= 1'b0;
        end else begin
            sync1_ff     <= {i_hw_reset_n, i_strobe_mask_line, i_cs_n, i_bus_clk_true, i_dq};
            sync2_ff     <= sync1_ff;
            bclk_prev_ff <= sync2_ff[BYTE_W];
        end
    end

    wire              hw_rst_n_s = sync2_ff[SYNC_W-1];
    wire              mask_s     = sync2_ff[SYNC_W-2];
    wire              cs_n_s     = sync2_ff[SYNC_W-3];
    wire              bclk_s     = sync2_ff[BYTE_W];
    wire [BYTE_W-1:0] dq_s       = sync2_ff[BYTE_W-1:0];
    wire              bus_edge   = bclk_s ^ bclk_prev_ff;
    wire              abort      = cs_n_s | ~hw_rst_n_s;

    // ****************************************************************
    // transfer state and decode
    // ****************************************************************
    xfer_state_e       state_ff;
    xfer_state_e       nxt_state;
    logic [CNT_W-1:0]  cnt_ff;
    logic [CA_W-1:0]   ca_ff;
    logic              is_read_ff;
    logic              linear_ff;
    logic              hybrid_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [ADDR_W-1:0] wmask_ff;
    logic [ADDR_W-1:0] wcnt_ff;
    logic [WORD_W-1:0] rd_word;
    logic              pending_ff;

    wire [CA_W-1:0] ca_shift  = {ca_ff[CA_W-BYTE_W-1:0], dq_s};
    // sixth command edge ends the phase
    wire ca_last   = (state_ff == ST_CA) && bus_edge && (cnt_ff == CA_LAST);
    wire lat_last  = (state_ff == ST_LAT) && bus_edge && (cnt_ff == LAT_LAST);
    wire data_edge = (state_ff == ST_DATA) && bus_edge;
    wire hi_half   = ~cnt_ff[0];
    wire word_done = data_edge & cnt_ff[0];
    wire enter_ca  = (state_ff == ST_IDLE) && (nxt_state == ST_CA);
    wire nxt_is_read = ca_last ? ca_shift[CA_RW_BIT] : is_read_ff;
    // switch to linear after one full wrap
    wire hyb_switch = word_done & ~linear_ff & hybrid_ff & (wcnt_ff == wmask_ff);
    // linear steps stay inside the die
    wire [ADDR_W-1:0] adv_addr = hyb_switch ? lin_inc(addr_ff | wmask_ff) :
                                 linear_ff  ? lin_inc(addr_ff) :
                                              wrap_inc(addr_ff, wmask_ff);
    // mask from the host on writes
    wire              wr_en   = data_edge & ~is_read_ff & ~mask_s;
    wire [1:0]        wr_be   = hi_half ? 2'b10 : 2'b01;
    wire [WORD_W-1:0] wr_data = {dq_s, dq_s};

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: if (!abort) nxt_state = ST_CA;
            ST_CA:   if (ca_last) nxt_state = ST_LAT;
            ST_LAT:  if (lat_last) nxt_state = ST_DATA;
            ST_DATA: nxt_state = ST_DATA;
            default: nxt_state = ST_IDLE;
        endcase
        if (abort) begin
            nxt_state = ST_IDLE;
        end
    end

    wire              cnt_clr = (nxt_state != state_ff) || (state_ff == ST_IDLE);
    wire [CNT_W-1:0]  nxt_cnt = cnt_clr ? '0 : (bus_edge ? cnt_ff + 1'b1 : cnt_ff);

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            state_ff <= ST_IDLE;
            cnt_ff   <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
        end
    end

    // ****************************************************************
    // command capture and burst address
    // ****************************************************************
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            ca_ff      <= '0;
            is_read_ff <= 1'b0;
            linear_ff  <= 1'b0;
            hybrid_ff  <= 1'b0;
            addr_ff    <= '0;
            wmask_ff   <= '0;
            wcnt_ff    <= '0;
        end else begin
            if ((state_ff == ST_CA) && bus_edge) begin
                ca_ff <= ca_shift;
            end
            if (ca_last) begin
                is_read_ff <= ca_shift[CA_RW_BIT];
                linear_ff  <= ca_shift[CA_LINEAR_BIT];
                hybrid_ff  <= i_hybrid_en;
                addr_ff    <= ca_shift[ADDR_W-1:0];
                wmask_ff   <= wrap_mask(i_wrap_len_sel);
                wcnt_ff    <= '0;
            end else if (word_done && !abort) begin
                addr_ff   <= adv_addr;
                linear_ff <= linear_ff | hyb_switch;
                wcnt_ff   <= wcnt_ff + 1'b1;
            end
        end
    end

    // registered read, one cycle behind address
    psram_word_array #(
        .ADDR_W    (ADDR_W)
    ) u_array (
        .i_clk_sys (i_clk_sys),
        .i_wr_en   (wr_en),
        .i_wr_be   (wr_be),
        .i_wr_data (wr_data),
        .i_addr    (addr_ff),
        .o_rd_data (rd_word)
    );

    // ****************************************************************
    // pin drivers
    // ****************************************************************
    // strobe driven from transaction start
    // refresh flag shown during command phase
    // strobe follows the bus clock on reads
    wire nxt_strobe = enter_ca ? pending_ff :
                      (state_ff == ST_CA && nxt_state == ST_CA) ? o_strobe_mask_line :
                      (data_edge && is_read_ff) ? bclk_s :
                      (state_ff == ST_DATA && nxt_state == ST_DATA) ? o_strobe_mask_line :
                      1'b0;
    wire nxt_strobe_oe = (nxt_state == ST_CA) ||
                         (((nxt_state == ST_LAT) || (nxt_state == ST_DATA)) && nxt_is_read);
    wire nxt_dq_oe = (nxt_state == ST_DATA) && nxt_is_read;

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            o_dq               <= '0;
            o_dq_oe            <= 1'b0;
            o_strobe_mask_line <= 1'b0;
            o_strobe_mask_oe   <= 1'b0;
        end else begin
            // byte changes on the strobe edge
            if (data_edge && is_read_ff) begin
                o_dq <= hi_half ? rd_word[WORD_W-1:BYTE_W] : rd_word[BYTE_W-1:0];
            end
            o_dq_oe            <= nxt_dq_oe;
            o_strobe_mask_line <= nxt_strobe;
            o_strobe_mask_oe   <= nxt_strobe_oe;
        end
    end

    // ****************************************************************
    // self refresh
    // ****************************************************************
    logic [INTV_W-1:0] intv_cnt_ff;
    logic [PEN_W-1:0]  pen_cnt_ff;
    logic              run_ff;

    wire intv_done     = (intv_cnt_ff == INTV_LAST);
    // refresh starts only on an idle bus
    wire refresh_start = pending_ff & ~run_ff & (state_ff == ST_IDLE) & cs_n_s;
    wire refresh_done  = run_ff & (pen_cnt_ff == PEN_LAST);

    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            intv_cnt_ff <= '0;
            pen_cnt_ff  <= '0;
            run_ff      <= 1'b0;
            pending_ff  <= 1'b0;
        end else begin
            intv_cnt_ff <= intv_done ? '0 : intv_cnt_ff + 1'b1;
            pen_cnt_ff  <= run_ff ? pen_cnt_ff + 1'b1 : '0;
            run_ff      <= refresh_start | (run_ff & ~refresh_done);
            pending_ff  <= intv_done | (pending_ff & ~refresh_done);
        end
    end

    assign o_refresh_pending = pending_ff;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);

    property p_ca_six;
        (state_ff == ST_CA) && bus_edge && (cnt_ff < CA_LAST) && !abort |=> state_ff == ST_CA;
    endproperty
    a_ca_six: assert property (p_ca_six) else $error("command phase ended early");

    property p_ca_to_lat;
        ca_last && !abort |=> (state_ff == ST_LAT) && (cnt_ff == '0);
    endproperty
    a_ca_to_lat: assert property (p_ca_to_lat) else $error("no latency after command");

    property p_lat_ext;
        (state_ff == ST_LAT) && bus_edge && (cnt_ff < LAT_LAST) && !abort |=> state_ff == ST_LAT;
    endproperty
    a_lat_ext: assert property (p_lat_ext) else $error("latency shorter than extended");

    property p_strobe_refresh;
        enter_ca |=> o_strobe_mask_oe && (o_strobe_mask_line == $past(pending_ff));
    endproperty
    a_strobe_refresh: assert property (p_strobe_refresh) else $error("refresh flag wrong");

    property p_read_strobe;
        (state_ff == ST_DATA) && is_read_ff && !bus_edge && !abort |=> $stable(o_strobe_mask_line);
    endproperty
    a_read_strobe: assert property (p_read_strobe) else $error("strobe moved off edge");

    property p_read_data;
        data_edge && is_read_ff && hi_half && !abort
            |=> (o_dq == $past(rd_word[WORD_W-1:BYTE_W])) && (o_strobe_mask_line == $past(bclk_s));
    endproperty
    a_read_data: assert property (p_read_data) else $error("read byte not edge aligned");

    property p_mask;
        data_edge && !is_read_ff && hi_half && mask_s && !abort
            |=> ##1 rd_word[WORD_W-1:BYTE_W] == $past(rd_word[WORD_W-1:BYTE_W], 2);
    endproperty
    a_mask: assert property (p_mask) else $error("masked byte written");

    property p_wrap;
        word_done && !linear_ff && !hyb_switch && !abort
            |=> (addr_ff & ~wmask_ff) == ($past(addr_ff) & ~$past(wmask_ff));
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap left its group");

    property p_die_wrap;
        word_done && linear_ff && (&addr_ff[ADDR_W-2:0]) && !abort
            |=> addr_ff == {$past(addr_ff[ADDR_W-1]), (ADDR_W-1)'(0)};
    endproperty
    a_die_wrap: assert property (p_die_wrap) else $error("die end did not wrap");

    property p_refresh_idle;
        refresh_start |-> (state_ff == ST_IDLE) && cs_n_s ##1 run_ff;
    endproperty
    a_refresh_idle: assert property (p_refresh_idle) else $error("refresh on busy bus");

    property p_release;
        abort |=> !o_dq_oe && !o_strobe_mask_oe && (state_ff == ST_IDLE);
    endproperty
    a_release: assert property (p_release) else $error("lines held after deselect");

endmodule

`default_nettype wire

/* File: bench/psram_host_model.sv */
/*
 * Host bus master model: drives select, bus clock, command bytes,
 * write data and mask, and keeps the read bytes and strobe it sees.
 * Assumes the bench resolves the shared pins from both drivers.
 */
`timescale 1ns/10ps
`default_nettype none

module psram_host_model
    import psram_slave_pkg::*;
#(
    parameter int LAT_CLKS = 6
) (
    // clock
    input  wire logic       i_clk_sys,
    // resolved pins
    input  wire logic [7:0] i_dq,
    input  wire logic       i_strobe,
    // host drive
    output var  logic       o_cs_n,
    output var  logic       o_bus_clk,
    output var  logic [7:0] o_dq,
    output var  logic       o_mask
);
    logic [7:0] wbuf [0:255];
    logic       mbuf [0:255];
    logic [7:0] rbuf [0:255];
    logic       sbuf [0:255];
    logic [7:0] smp_dq;
    logic       smp_st;

    initial begin
        o_cs_n    = 1'b1;
        o_bus_clk = 1'b0;
        o_dq      = 8'h00;
        o_mask    = 1'b0;
    end

    // ****************************************************************
    // one bus edge
    // ****************************************************************
    // byte held round edge, 800 ns period
    task automatic step(input logic [7:0] d, input logic m, input logic drv, input logic drm);
        o_dq   <= drv ? d : ~o_dq;
        o_mask <= drm ? m : ~o_mask;
        repeat (2) @(negedge i_clk_sys);
        smp_dq = i_dq;
        smp_st = i_strobe;
        o_bus_clk <= ~o_bus_clk;
        repeat (2) @(negedge i_clk_sys);
    endtask

    // ****************************************************************
    // whole transaction
    // ****************************************************************
    // select, command, extended wait, data
    task automatic xfer(input logic [47:0] ca, input int nb, input logic wr, output logic pend);
        int i;
        @(negedge i_clk_sys);
        o_cs_n <= 1'b0;
        // undriven strobe line would read high
        o_mask <= 1'b1;
        repeat (4) @(negedge i_clk_sys);
        pend = i_strobe;
        for (i = 0; i < CA_BYTES; i++)
            step(ca[47 - 8 * i -: 8], 1'b0, 1'b1, 1'b0);
        for (i = 0; i < LAT_CLKS * 2 * LAT_MULT_EXT; i++)
            step(8'h00, 1'b0, 1'b0, 1'b0);
        for (i = 0; i < nb; i++) begin
            step(wbuf[i], mbuf[i], wr, wr);
            if (i > 0) begin
                rbuf[i - 1] = smp_dq;
                sbuf[i - 1] = smp_st;
            end
        end
        repeat (2) @(negedge i_clk_sys);
        rbuf[nb - 1] = i_dq;
        sbuf[nb - 1] = i_strobe;
        o_cs_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

/* File: bench/ddr_psram_slave_port_test.sv */
/*
 * Self-checking bench of the slave port: masked writes, read strobe,
 * every wrap length, hybrid burst, die wrap and refresh flag.
 * Assumes the host model drives all bus pins the device listens to except hardware reset, which the bench ties high.
 */
`timescale 1ns/10ps
`default_nettype none

module ddr_psram_slave_port_test;
    import psram_slave_pkg::*;

    // ****************************************************************
    // signals and instances
    // ****************************************************************
    logic        clk_sys  = 1'b0;
    logic        resetn   = 1'b0;
    logic [1:0]  wrap_sel = 2'h0;
    logic        hybrid   = 1'b0;
    wire logic   cs_n, bus_clk, h_mask, st_pin, dut_st, dut_st_oe, dut_dq_oe, pending;
    wire logic [7:0] h_dq, dq_pin, dut_dq;
    logic [15:0] ex [0:127];
    logic        pend;
    int          fail_count = 0;
    int          cmp_count  = 0;

    assign dq_pin = dut_dq_oe ? dut_dq : h_dq;
    assign st_pin = dut_st_oe ? dut_st : h_mask;

    ddr_psram_slave_port #(
        .REFRESH_INTERVAL_CYC (400),
        .REFRESH_PENALTY_CYC  (8)
    ) u_dut (
        .i_clk_sys          (clk_sys),
        .i_resetn           (resetn),
        .i_cs_n             (cs_n),
        .i_bus_clk_true     (bus_clk),
        .i_hw_reset_n       (1'b1),
        .i_dq               (dq_pin),
        .o_dq               (dut_dq),
        .o_dq_oe            (dut_dq_oe),
        .i_strobe_mask_line (st_pin),
        .o_strobe_mask_line (dut_st),
        .o_strobe_mask_oe   (dut_st_oe),
        .i_wrap_len_sel     (wrap_sel),
        .i_hybrid_en        (hybrid),
        .o_refresh_pending  (pending)
    );

    psram_host_model u_host (
        .i_clk_sys (clk_sys),
        .i_dq      (dq_pin),
        .i_strobe  (st_pin),
        .o_cs_n    (cs_n),
        .o_bus_clk (bus_clk),
        .o_dq      (h_dq),
        .o_mask    (h_mask)
    );

    always #50 clk_sys = ~clk_sys;

    // ****************************************************************
    // shared tasks
    // ****************************************************************
    function automatic logic [15:0] pat(input logic [7:0] a);
        return {~a, a};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic put(input int i, input logic [15:0] w, input logic [1:0] m);
        u_host.wbuf[2 * i]     = w[15:8];
        u_host.wbuf[2 * i + 1] = w[7:0];
        u_host.mbuf[2 * i]     = m[1];
        u_host.mbuf[2 * i + 1] = m[0];
    endtask

    task automatic released;
        repeat (3) @(negedge clk_sys);
        chk({14'h0, dut_dq_oe, dut_st_oe}, 16'h0000);
    endtask

    task automatic wr(input logic [7:0] a, input int nw);
        u_host.xfer({1'b0, 1'b0, 1'b1, 37'h0, a}, 2 * nw, 1'b1, pend);
        released();
    endtask

    task automatic rd(input logic [7:0] a, input logic lin, input int nw);
        int i;
        u_host.xfer({1'b1, 1'b0, lin, 37'h0, a}, 2 * nw, 1'b0, pend);
        for (i = 0; i < 2 * nw; i++) begin
            chk({8'h00, u_host.rbuf[i]}, {8'h00, i[0] ? ex[i / 2][7:0] : ex[i / 2][15:8]});
            chk({15'h0, u_host.sbuf[i]}, {15'h0, ~i[0]});
        end
        released();
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        chk({13'h0, dut_dq_oe, dut_st_oe, pending}, 16'h0000);
        $display("test reset done");
    endtask

    task automatic t_mask;
        put(0, 16'h1111, 2'b00);
        put(1, 16'h2222, 2'b00);
        wr(8'h10, 2);
        chk({15'h0, pend}, 16'h0000);
        put(0, 16'haaaa, 2'b01);
        put(1, 16'hbbbb, 2'b10);
        wr(8'h10, 2);
        ex[0] = 16'haa11;
        ex[1] = 16'h22bb;
        rd(8'h10, 1'b1, 2);
        $display("test masked write done");
    endtask

    task automatic t_burst;
        int i;
        int w;
        int n;
        logic [7:0] b;
        for (i = 0; i < 66; i++)
            put(i, pat(8'(8'h40 + i) & 8'h7f), 2'b00);
        wr(8'h40, 66);
        chk({15'h0, pending}, 16'h0001);
        for (i = 0; i < 4; i++)
            ex[i] = pat(8'(8'h7e + i) & 8'h7f);
        rd(8'h7e, 1'b1, 4);
        chk({15'h0, pend}, 16'h0001);
        for (w = 0; w < 4; w++) begin
            wrap_sel = w[1:0];
            n = WRAP_WORDS_16B << w;
            b = 8'h7e & ~8'(n - 1);
            for (i = 0; i < n + 2; i++)
                ex[i] = pat(b + 8'((8'h7e - b + i) % n));
            rd(8'h7e, 1'b0, n + 2);
        end
        wrap_sel = WRAP_SEL_16B;
        hybrid = 1'b1;
        for (i = 0; i < 10; i++)
            ex[i] = pat(8'h70 + 8'(i < 8 ? (6 + i) % 8 : i));
        rd(8'h76, 1'b0, 10);
        hybrid = 1'b0;
        $display("test bursts done");
    endtask

    // ****************************************************************
    // run control
    // ****************************************************************
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (16) @(negedge clk_sys);
        resetn = 1'b1;
        @(negedge clk_sys);
        t_reset();
        t_mask();
        t_burst();
        give_verdict();
    end

    initial begin
        repeat (12000) @(posedge clk_sys);
        fail_count++;
        give_verdict();
    end
endmodule

`default_nettype wire
